/* File: flash_suspend_and_lock_sequencer_test.sv */
// testbench: suspend, resume and lock sequences against the flash model
`timescale 1ns/100ps
`default_nettype none
module flash_suspend_and_lock_sequencer_test;
  import fss_pkg::*;
  logic CLK = 0, NRST = 0, REQ = 0, HOLD_PROTECT = 0, BUSY, DONE, REFUSED;
  logic ES, WS, ERR, DQ_OE, CE_N, WE_N, OE_N, RB;
  fss_op_t OP = OP_READ_STAT;
  logic [AW-1:0] ADDR = '0;
  logic [DW-1:0] DQ_O, DQ_I;
  logic [7:0] STATUS;
  logic [AW-1:0] FA;
  logic RST_PIN, PROT_N;
  int errors = 0, checks_done = 0, cyc = 0;
  fss_host u_fss_host (.CLK(CLK), .NRST(NRST), .REQ(REQ), .OP(OP), .ADDR(ADDR),
    .HOLD_PROTECT(HOLD_PROTECT), .BUSY(BUSY), .DONE(DONE), .STATUS(STATUS),
    .ERASE_SUSPENDED(ES), .WRITE_SUSPENDED(WS), .ANY_ERROR(ERR), .REFUSED(REFUSED),
    .F_ADDR(FA), .F_DQ_OUT(DQ_O), .F_DQ_OE(DQ_OE), .F_DQ_IN(DQ_I), .F_CE_N(CE_N),
    .F_WE_N(WE_N), .F_OE_N(OE_N), .F_RESET_N(RST_PIN), .F_PROTECT_N(PROT_N),
    .F_READY_BUSY(RB));
  fss_flash_model u_fss_flash_model (.ce_n(CE_N), .we_n(WE_N), .oe_n(OE_N),
    .dq_out(DQ_O), .dq_in(DQ_I), .ready_busy(RB));
  initial forever #12.5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      tally_and_finish();
    end
  end
  task check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one command, wait for its end, judge refusal
  task cmd(input fss_op_t o, input logic rf);
    int n;
    n = 0;
    @(posedge CLK);
    #2 REQ = 1;
    OP = o;
    ADDR = ADDR + 20'h10000;
    @(posedge CLK);
    #2 REQ = 0;
    while (DONE !== 1'b1 && n < 4000) begin
      @(posedge CLK);
      #2 n++;
    end
    check({BUSY, DONE}, 2'b01);
    check(REFUSED, rf);
    if (!rf)
      check(FA[19:12], ADDR[19:12]);
  endtask
  task t_erase_suspend;
    u_fss_flash_model.go(40, 0);
    cmd(OP_SUSPEND, 0);
    check(STATUS[7:6], 2'b11);
    check(RB, 1);
    HOLD_PROTECT = 1;
    cmd(OP_SET_BLOCK, 1);
    cmd(OP_CLEAR_STAT, 1);
    check(ES, 1);
    check(PROT_N, 1);
    check(RST_PIN, 1);
    HOLD_PROTECT = 0;
    // each resume runs to completion before the next suspend
    cmd(OP_RESUME, 0);
    check(STATUS[7:6], 2'b10);
    cmd(OP_SUSPEND, 0);
    check(ES, 0);
    $display("test erase suspend done");
  endtask
  task t_write_suspend;
    u_fss_flash_model.go(40, 1);
    cmd(OP_SUSPEND, 0);
    check(STATUS & 8'hC4, 8'h84);
    cmd(OP_SUSPEND, 1);
    cmd(OP_READ_STAT, 0);
    check(WS, 1);
    cmd(OP_READ_ARRAY, 0);
    check(WS, 1);
    cmd(OP_RESUME, 0);
    check(STATUS & 8'h84, 8'h80);
    $display("test write suspend done");
  endtask
  task t_locks;
    HOLD_PROTECT = 1;
    cmd(OP_SET_BLOCK, 0);
    check(ERR, 0);
    check(PROT_N, 0);
    HOLD_PROTECT = 0;
    cmd(OP_CLEAR_LOCKS, 0);
    check(STATUS, 8'h80);
    cmd(OP_SET_PERM, 0);
    cmd(OP_SET_BLOCK, 0);
    check(STATUS, 8'h92);
    cmd(OP_READ_STAT, 0);
    check(STATUS, 8'h92);
    cmd(OP_CLEAR_LOCKS, 0);
    check(STATUS, 8'hB2);
    cmd(OP_CLEAR_STAT, 0);
    check(ERR, 0);
    $display("test locks done");
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge CLK);
    #2 NRST = 1;
    repeat (4) @(posedge CLK);
    t_erase_suspend();
    t_write_suspend();
    t_locks();
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: fss_flash_model.sv */
// behavioural flash: command decode, status byte, suspend and lock bits
`timescale 1ns/100ps
`default_nettype none
module fss_flash_model (
  // flash pins
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [15:0] dq_out,
  output logic      [15:0] dq_in,
  output logic             ready_busy
);
  logic [7:0] err, last, cmd;
  logic       es, ws, perm, kind, armed;
  int         cnt;
  wire        run = cnt != 0 && !es && !ws;
  wire  [7:0] sr  = {!run, es, err[5:3], ws, err[1], 1'b0};
  // released bus shows the inverse so a stale read cannot match
  assign dq_in = (!ce_n && !oe_n) ? {8'h00, sr} : {8'hFF, ~sr};
  assign ready_busy = !run;
  initial {err, last, cmd, es, ws, perm, kind, armed, cnt} = '0;
  always #100 if (run) cnt--;
  task go(input int n, input logic w);
    cnt = n;
    kind = w;
  endtask
  // ====
  // command decode on the write strobe's rising edge
  always @(we_n, ce_n) begin
    if (!we_n && !ce_n) begin
      cmd = dq_out[7:0];
      armed = 1;
    end else if (armed) begin
      armed = 0;
      case (cmd)
        8'hB0: if (run) {ws, es} = kind ? 2'b10 : 2'b01;
        8'hD0: if (last == 8'h60) begin
          if (perm) {err[1], err[5]} = 2'b11;
          else cnt = 3;
        end else if (ws) ws = 0;
        else es = 0;
        8'h01, 8'hF1: if (last != 8'h60) {err[4], err[5]} = 2'b11;
        else if (perm) {err[1], err[4]} = 2'b11;
        else begin
          perm = perm | (cmd == 8'hF1);
          cnt = 3;
        end
        8'h50: err = 0;
        default: ;
      endcase
      last = cmd;
    end
  end
endmodule
`default_nettype wire

/* File: fss_host.sv */
// host controller issuing suspend, resume, lock and status command cycles to the flash
// Operation
// - suspend then read status, test erase-suspended
// - hold reset deasserted, protect level steady
// - write suspend then read status, check flag
// - avoid rapid repeated resume then suspend
// - lock set is setup then confirm cycle
// - after lock set check write error
// - aborted clear lock-bits must be repeated
// - error flags stay until clear status
`timescale 1ns/100ps
`default_nettype none
module fss_host
  import fss_pkg::*;
(
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             NRST,
  // user command port
  input  wire logic             REQ,
  input  wire fss_pkg::fss_op_t OP,
  input  wire logic [fss_pkg::AW-1:0] ADDR,
  input  wire logic             HOLD_PROTECT,
  output logic                  BUSY,
  output logic                  DONE,
  output logic [7:0]            STATUS,
  output logic                  ERASE_SUSPENDED,
  output logic                  WRITE_SUSPENDED,
  output logic                  ANY_ERROR,
  output logic                  REFUSED,
  // flash pins
  output logic [fss_pkg::AW-1:0] F_ADDR,
  output logic [fss_pkg::DW-1:0] F_DQ_OUT,
  output logic                  F_DQ_OE,
  input  wire logic [fss_pkg::DW-1:0] F_DQ_IN,
  output logic                  F_CE_N,
  output logic                  F_WE_N,
  output logic                  F_OE_N,
  output logic                  F_RESET_N,
  output logic                  F_PROTECT_N,
  input  wire logic             F_READY_BUSY
);
  import fss_pkg::*;

  // ==========================================================
  // reset and pin synchronisers
  logic       rst_s1;
  logic       rst_n;
  logic [7:0] dq_s1;
  logic [7:0] dq_s2;
  logic       rb_s1;
  logic       rb_s2;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
      rb_s1 <= 1'b0;
      rb_s2 <= 1'b0;
    end else begin
      dq_s1 <= F_DQ_IN[7:0];
      dq_s2 <= dq_s1;
      rb_s1 <= F_READY_BUSY;
      rb_s2 <= rb_s1;
    end
  end

  // ==========================================================
  // command sequencing
  fss_state_t state;
  logic [3:0] cnt;
  logic [1:0] cyc;
  logic [1:0] ncyc;
  fss_op_t    op;
  logic [AW-1:0] addr;
  logic [7:0] code0;
  logic [7:0] code1;
  logic       poll;
  logic       accept;
  logic       allowed;

  function automatic logic suspend_ok(input fss_op_t o, input logic es, input logic ws);
    // only status, resume and reads while write suspended; erase suspend also takes suspend
    if (ws)
      return (o == OP_READ_STAT) || (o == OP_RESUME) || (o == OP_READ_ARRAY);
    if (es)
      return (o == OP_READ_STAT) || (o == OP_RESUME) || (o == OP_READ_ARRAY) ||
             (o == OP_SUSPEND);
    return 1'b1;
  endfunction

  assign allowed = suspend_ok(OP, ERASE_SUSPENDED, WRITE_SUSPENDED);
  assign accept  = REQ && (state == ST_IDLE);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt   <= 4'h0;
      cyc   <= 2'h0;
      ncyc  <= 2'h0;
      op    <= OP_READ_STAT;
      addr  <= '0;
      code0 <= 8'h00;
      code1 <= 8'h00;
      poll  <= 1'b0;
      DONE  <= 1'b0;
      REFUSED <= 1'b0;
    end else begin
      DONE    <= 1'b0;
      REFUSED <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (accept && !allowed) begin
            REFUSED <= 1'b1;
            DONE    <= 1'b1;
          end else if (accept) begin
            op   <= OP;
            addr <= ADDR;
            cyc  <= 2'h0;
            cnt  <= BUS_CNT;
            poll <= 1'b0;
            state <= ST_WLOW;
            unique case (OP)
              OP_SUSPEND: begin
                code0 <= CMD_SUSPEND;
                code1 <= CMD_READ_STATUS;
                ncyc  <= 2'h2;
              end
              OP_RESUME: begin
                code0 <= CMD_RESUME;
                code1 <= CMD_READ_STATUS;
                ncyc  <= 2'h1;
              end
              OP_SET_BLOCK: begin
                code0 <= CMD_LOCK_SETUP;
                code1 <= CMD_SET_BLOCK;
                ncyc  <= 2'h2;
              end
              OP_SET_PERM: begin
                code0 <= CMD_LOCK_SETUP;
                code1 <= CMD_SET_PERM;
                ncyc  <= 2'h2;
              end
              OP_CLEAR_LOCKS: begin
                code0 <= CMD_LOCK_SETUP;
                code1 <= CMD_CLEAR_LOCKS;
                ncyc  <= 2'h2;
              end
              OP_CLEAR_STAT: begin
                code0 <= CMD_CLEAR_STATUS;
                code1 <= CMD_READ_STATUS;
                ncyc  <= 2'h1;
              end
              OP_READ_STAT: begin
                code0 <= CMD_READ_STATUS;
                code1 <= CMD_READ_STATUS;
                ncyc  <= 2'h1;
              end
              OP_READ_ARRAY: begin
                code0 <= CMD_READ_ARRAY;
                code1 <= CMD_READ_ARRAY;
                ncyc  <= 2'h1;
              end
            endcase
          end
        end
        ST_WLOW: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h1) begin
            cnt   <= BUS_CNT;
            state <= ST_WHIGH;
          end
        end
        ST_WHIGH: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h1) begin
            cnt <= BUS_CNT;
            cyc <= cyc + 2'h1;
            if (cyc + 2'h1 < ncyc)
              state <= ST_WLOW;
            else if (op == OP_READ_ARRAY || op == OP_CLEAR_STAT)
              state <= ST_DONE;
            else
              state <= ST_RLOW;
          end
        end
        ST_RLOW: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h1) begin
            cnt   <= BUS_CNT;
            state <= ST_RHIGH;
          end
        end
        ST_RHIGH: begin
          // status latched on falling edge, so strobe high between polls
          cnt <= cnt - 4'h1;
          if (cnt == 4'h1) begin
            cnt  <= BUS_CNT;
            poll <= 1'b1;
            if (STATUS[BIT_READY] && rb_s2 && poll)
              state <= ST_DONE;
            else
              state <= ST_RLOW;
          end
        end
        ST_DONE: begin
          DONE  <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // status capture
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      STATUS <= 8'h00;
    end else if (state == ST_RLOW && cnt == 4'h1) begin
      STATUS <= dq_s2;
    end else if (state == ST_DONE && op == OP_CLEAR_STAT) begin
      // only the error flags drop; ready and suspend flags keep their last poll
      STATUS[BIT_ERASE_ERR] <= 1'b0;
      STATUS[BIT_WRITE_ERR] <= 1'b0;
      STATUS[BIT_VPP_LOW]   <= 1'b0;
      STATUS[BIT_LOCK_VIOL] <= 1'b0;
    end
  end

  assign ERASE_SUSPENDED = STATUS[BIT_ERASE_SUSP];
  assign WRITE_SUSPENDED = STATUS[BIT_WRITE_SUSP];
  assign ANY_ERROR = STATUS[BIT_ERASE_ERR] | STATUS[BIT_WRITE_ERR] |
                     STATUS[BIT_VPP_LOW] | STATUS[BIT_LOCK_VIOL];
  assign BUSY = (state != ST_IDLE);

  // ==========================================================
  // pin drive
  logic writing;
  assign writing = (state == ST_WLOW) || (state == ST_WHIGH);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      F_ADDR      <= '0;
      F_DQ_OUT    <= '0;
      F_DQ_OE     <= 1'b0;
      F_CE_N      <= 1'b1;
      F_WE_N      <= 1'b1;
      F_OE_N      <= 1'b1;
      F_RESET_N   <= 1'b1;
      F_PROTECT_N <= 1'b1;
    end else begin
      F_RESET_N <= 1'b1;
      // protect level frozen while any suspension holds
      if (!HOLD_PROTECT && !ERASE_SUSPENDED && !WRITE_SUSPENDED)
        F_PROTECT_N <= 1'b1;
      else if (HOLD_PROTECT && !ERASE_SUSPENDED && !WRITE_SUSPENDED)
        F_PROTECT_N <= 1'b0;
      F_ADDR   <= addr;
      F_DQ_OUT <= {8'h00, (cyc == 2'h0) ? code0 : code1};
      F_DQ_OE  <= writing;
      F_CE_N   <= !(state == ST_WLOW || state == ST_RLOW);
      F_WE_N   <= !(state == ST_WLOW);
      F_OE_N   <= !(state == ST_RLOW);
    end
  end
  // suspend pacing left to the user; no request queueing here
endmodule
`default_nettype wire

/* File: fss_host_asserts.sv */
// checker: pin and status relations of the flash host sequencer
`timescale 1ns/100ps
`default_nettype none
module fss_host_asserts
  import fss_pkg::*;
(
  // clock and reset
  input wire logic       CLK,
  input wire logic       NRST,
  // user side
  input wire logic       REQ,
  input wire fss_op_t    OP,
  input wire logic       BUSY,
  input wire logic       DONE,
  input wire logic       REFUSED,
  input wire logic [7:0] STATUS,
  input wire logic       ERASE_SUSPENDED,
  input wire logic       WRITE_SUSPENDED,
  input wire logic       ANY_ERROR,
  // flash pins
  input wire logic       F_DQ_OE,
  input wire logic       F_WE_N,
  input wire logic       F_OE_N,
  input wire logic       F_RESET_N,
  input wire logic       F_PROTECT_N
);
  // ====
  // properties
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_esusp;
    REQ && !BUSY && ERASE_SUSPENDED &&
    (OP == OP_SET_BLOCK || OP == OP_SET_PERM || OP == OP_CLEAR_LOCKS || OP == OP_CLEAR_STAT)
    |=> REFUSED;
  endproperty
  a_esusp: assert property (p_esusp) else $error("erase suspend let op through");
  property p_wsusp; REQ && !BUSY && WRITE_SUSPENDED && OP == OP_SUSPEND |=> REFUSED; endproperty
  a_wsusp: assert property (p_wsusp) else $error("write suspend let op through");
  property p_err; $fell(ANY_ERROR) |-> DONE; endproperty
  a_err: assert property (p_err) else $error("error flags dropped without clear");
  property p_rst; F_RESET_N; endproperty
  a_rst: assert property (p_rst) else $error("reset pin asserted");
  property p_prot; ERASE_SUSPENDED && $past(ERASE_SUSPENDED) |-> $stable(F_PROTECT_N); endproperty
  a_prot: assert property (p_prot) else $error("protect moved");
  property p_quiet; REFUSED |-> DONE && F_WE_N && F_OE_N; endproperty
  a_quiet: assert property (p_quiet) else $error("refused op touched pins");
  property p_refwhy; REFUSED |-> ERASE_SUSPENDED || WRITE_SUSPENDED; endproperty
  a_refwhy: assert property (p_refwhy) else $error("refused outside suspend");
  property p_we; $fell(F_WE_N) |-> (!F_WE_N)[*4] ##1 F_WE_N; endproperty
  a_we: assert property (p_we) else $error("write strobe length");
  property p_bus; !F_OE_N |-> !F_DQ_OE; endproperty
  a_bus: assert property (p_bus) else $error("data bus contention");
  property p_done; DONE && !REFUSED |-> STATUS[BIT_READY]; endproperty
  a_done: assert property (p_done) else $error("done while busy");
  c_es: cover property ($rose(ERASE_SUSPENDED));
  c_ws: cover property ($rose(WRITE_SUSPENDED));
  c_ref: cover property (REFUSED);
  c_viol: cover property ($rose(STATUS[BIT_LOCK_VIOL]));
endmodule
bind fss_host fss_host_asserts u_fss_host_asserts (.CLK, .NRST, .REQ, .OP, .BUSY,
  .DONE, .REFUSED, .STATUS,
  .ERASE_SUSPENDED, .WRITE_SUSPENDED, .ANY_ERROR, .F_DQ_OE, .F_WE_N, .F_OE_N,
  .F_RESET_N, .F_PROTECT_N);
`default_nettype wire

/* File: fss_pkg.sv */
// package: command codes, status bit positions and timing for the flash host sequencer
package fss_pkg;
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0] CMD_RESUME       = 8'hD0;
  localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
  localparam logic [7:0] CMD_SET_BLOCK    = 8'h01;
  localparam logic [7:0] CMD_SET_PERM     = 8'hF1;
  localparam logic [7:0] CMD_CLEAR_LOCKS  = 8'hD0;
  localparam int BIT_READY      = 7;
  localparam int BIT_ERASE_SUSP = 6;
  localparam int BIT_ERASE_ERR  = 5;
  localparam int BIT_WRITE_ERR  = 4;
  localparam int BIT_VPP_LOW    = 3;
  localparam int BIT_WRITE_SUSP = 2;
  localparam int BIT_LOCK_VIOL  = 1;
  localparam int AW = 20;
  localparam int DW = 16;
  localparam int CLK_MHZ = 40;
  localparam int BUS_LOW_NS = 100;
  localparam int BUS_CYC = (BUS_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] BUS_CNT = 4'(BUS_CYC);
  typedef enum logic [2:0] {
    OP_SUSPEND     = 3'b000,
    OP_RESUME      = 3'b001,
    OP_SET_BLOCK   = 3'b010,
    OP_SET_PERM    = 3'b011,
    OP_CLEAR_LOCKS = 3'b100,
    OP_CLEAR_STAT  = 3'b101,
    OP_READ_STAT   = 3'b110,
    OP_READ_ARRAY  = 3'b111
  } fss_op_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WLOW  = 3'b001,
    ST_WHIGH = 3'b010,
    ST_RLOW  = 3'b011,
    ST_RHIGH = 3'b100,
    ST_DONE  = 3'b101
  } fss_state_t;
endpackage
